// File: fmt_pkg.sv
package fmt_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [11:0] FMT_OFS_CTRL = 12'h000;
    localparam logic [11:0] FMT_OFS_OPER = 12'h004;
    localparam logic [11:0] FMT_OFS_TEMP_FLT = 12'h008;
    localparam logic [11:0] FMT_OFS_TEMP_WARN = 12'h00c;
    localparam logic [11:0] FMT_OFS_DRV_LIM = 12'h010;
    localparam logic [11:0] FMT_OFS_ACTION = 12'h014;
    localparam logic [11:0] FMT_OFS_VOUT_NOM = 12'h018;
    localparam logic [11:0] FMT_OFS_MARGIN = 12'h01c;
    localparam logic [11:0] FMT_OFS_RATE = 12'h020;
    localparam logic [11:0] FMT_OFS_TRACK = 12'h024;
    localparam logic [11:0] FMT_OFS_STATUS = 12'h028;
    localparam logic [11:0] FMT_OFS_TARGET = 12'h02c;
    localparam logic [11:0] FMT_OFS_DRV_READ = 12'h030;
    localparam logic [11:0] FMT_OFS_ONTIME = 12'h034;
    localparam logic [11:0] FMT_OFS_RETRY = 12'h038;
    // ==========================================================
    // reset values; temperatures are signed degrees C
    localparam logic signed [15:0] FMT_OT_FLT_RST = 16'sh007d;
    localparam logic signed [15:0] FMT_UT_FLT_RST = -16'sh002d;
    localparam logic signed [15:0] FMT_OT_WARN_RST = 16'sh0073;
    localparam logic signed [15:0] FMT_UT_WARN_RST = -16'sh0023;
    localparam logic [15:0] FMT_DRV_OV_RST = 16'hffff;
    localparam logic [15:0] FMT_DRV_UV_RST = 16'h0000;
    localparam logic [15:0] FMT_VOUT_NOM_RST = 16'h0400;
    localparam logic [7:0] FMT_RATE_RST = 8'h01;
    localparam logic [6:0] FMT_RATIO_RST = 7'h32;
    localparam logic [6:0] FMT_PCT_FULL = 7'h64;
    localparam logic [6:0] FMT_PCT_MARGIN = 7'h05;
    localparam logic [6:0] FMT_PCT_CLAMP = 7'h0a;
    localparam logic [15:0] FMT_ON_DLY_RST = 16'h0010;
    localparam logic [15:0] FMT_RISE_RST = 16'h0001;
    localparam logic [15:0] FMT_RETRY_RST = 16'h0100;
    localparam int FMT_DRV_SHIFT = 4;
    // ==========================================================
    // fault actions and operation margin codes
    typedef enum logic [1:0] {
        FMT_ACT_LATCH = 2'h0,
        FMT_ACT_RESTART = 2'h1,
        FMT_ACT_RETRY = 2'h2
    } fmt_act_e;
    localparam logic [1:0] FMT_MRG_NOM = 2'h0;
    localparam logic [1:0] FMT_MRG_LOW = 2'h1;
    localparam logic [1:0] FMT_MRG_HIGH = 2'h2;
    typedef enum logic [4:0] {
        FMT_ST_OFF = 5'b00001,
        FMT_ST_DELAY = 5'b00010,
        FMT_ST_RUN = 5'b00100,
        FMT_ST_FAULT = 5'b01000,
        FMT_ST_WAIT = 5'b10000
    } fmt_state_e;
    typedef struct packed {
        logic ot;
        logic ut;
        logic dov;
        logic duv;
    } fmt_flt_s;
endpackage

// File: fmt_supervisor.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
module fmt_supervisor
    import fmt_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable_pin,
    input wire logic signed [W-1:0] die_temp,
    input wire logic [W-1:0] driver_supply_monitor,
    input wire logic [W-1:0] tracking_reference_input,
    input wire logic peer_fault_in,
    output logic [W-1:0] vout_target,
    output logic output_on,
    output logic prebias_en,
    output logic alert_line,
    output logic host_port_reset,
    output logic inter_device_fault_bus_o,
    output logic inter_device_fault_bus_oe
);
    // ==========================================================
    // configuration registers
    logic [3:0] ctrl_q, ctrl_d;
    logic [1:0] margin_sel_q, margin_sel_d;
    logic signed [W-1:0] ot_flt_q, ot_flt_d, ut_flt_q, ut_flt_d;
    logic signed [W-1:0] ot_warn_q, ot_warn_d, ut_warn_q, ut_warn_d;
    logic [W-1:0] drv_supply_over_limit_q, drv_supply_over_limit_d;
    logic [W-1:0] drv_supply_under_limit_q, drv_supply_under_limit_d;
    logic [7:0] act_q, act_d;
    logic [W-1:0] nom_q, nom_d, mhi_q, mhi_d, mlo_q, mlo_d;
    logic [7:0] rate_q, rate_d;
    logic [9:0] track_q, track_d;
    logic [W-1:0] on_dly_q, on_dly_d, rise_q, rise_d, retry_q, retry_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic wr, rd;
    // ctrl bits: 0 op enable, 1 push-pull fault bus, 2 share group, 3 clear status
    // track: [1:0] mode 0 off 1 coincident 2 ratio, [8:2] ratio percent
    // write lands on the edge where the host sees pready high
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && penable && !pwrite && !pready;

    function automatic logic [W-1:0] pct(input logic [W-1:0] v, input logic [6:0] p);
        logic [W+6:0] prod;
        prod = v * p;
        return (W)'(prod / FMT_PCT_FULL);
    endfunction

    logic [W-1:0] clamp_v;
    assign clamp_v = nom_q + pct(nom_q, FMT_PCT_CLAMP);

    // ==========================================================
    // supervisor state
    fmt_state_e st_q, st_d;
    fmt_flt_s flt_q, flt_d, cause_q, cause_d;
    logic [W-1:0] cnt_q, cnt_d, tgt_q, tgt_d, slew_q, slew_d;
    logic en_q, en_d, alert_q, alert_d, hpr_q, hpr_d;
    logic [7:0] rate_cnt_q, rate_cnt_d;
    fmt_flt_s now;
    logic en_now, hot, any_flt, clear_ok, latch_any, retry_any;
    logic [W-1:0] want, trk_v, drv_read;

    assign drv_read = driver_supply_monitor << FMT_DRV_SHIFT;
    assign en_now = enable_pin && ctrl_q[0];

    always_comb
    begin
        now.ot = die_temp > ot_flt_q;
        now.ut = die_temp < ut_flt_q;
        now.dov = driver_supply_monitor > drv_supply_over_limit_q;
        now.duv = driver_supply_monitor < drv_supply_under_limit_q;
        any_flt = now.ot || now.ut || now.dov || now.duv;
        clear_ok = !(cause_q.ot && die_temp >= ot_warn_q)
            && !(cause_q.ut && die_temp <= ut_warn_q)
            && !now.dov && !now.duv && !now.ot && !now.ut;
        latch_any = (cause_q.ot && act_q[1:0] == FMT_ACT_LATCH)
            || (cause_q.ut && act_q[3:2] == FMT_ACT_LATCH)
            || (cause_q.dov && act_q[5:4] == FMT_ACT_LATCH)
            || (cause_q.duv && act_q[7:6] == FMT_ACT_LATCH);
        retry_any = (cause_q.ot && act_q[1:0] == FMT_ACT_RETRY)
            || (cause_q.ut && act_q[3:2] == FMT_ACT_RETRY)
            || (cause_q.dov && act_q[5:4] == FMT_ACT_RETRY)
            || (cause_q.duv && act_q[7:6] == FMT_ACT_RETRY);
        case (margin_sel_q)
            FMT_MRG_HIGH: want = mhi_q;
            FMT_MRG_LOW: want = mlo_q;
            default: want = nom_q;
        endcase
        if (want > clamp_v)
            want = clamp_v;
        // tracking reference follows, capped at own setpoint
        if (track_q[1:0] == 2'h2)
            trk_v = pct(tracking_reference_input, track_q[8:2]);
        else
            trk_v = tracking_reference_input;
        if (trk_v > want)
            trk_v = want;
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        cause_d = cause_q;
        en_d = en_now;
        slew_d = slew_q;
        rate_cnt_d = rate_cnt_q;
        tgt_d = tgt_q;
        // host port reset on disable-enable edge
        hpr_d = en_now && !en_q;
        // sticky: new fault sets win over software clear
        flt_d = ctrl_d[3] ? '0 : flt_q;
        flt_d = flt_d | now;
        alert_d = |flt_d;
        case (st_q)
            FMT_ST_OFF:
            begin
                tgt_d = '0;
                if (en_now)
                begin
                    cnt_d = '0;
                    st_d = FMT_ST_DELAY;
                end
            end
            FMT_ST_DELAY:
            begin
                cnt_d = cnt_q + 1'b1;
                if (track_q[1:0] != 2'h0 || cnt_q >= on_dly_q)
                begin
                    cnt_d = '0;
                    slew_d = '0;
                    st_d = FMT_ST_RUN;
                end
            end
            FMT_ST_RUN:
            begin
                if (track_q[1:0] != 2'h0)
                    tgt_d = trk_v;
                else if (tgt_q != want)
                begin
                    // slew one code per rate period
                    rate_cnt_d = rate_cnt_q + 1'b1;
                    if (rate_cnt_q >= rate_q)
                    begin
                        rate_cnt_d = '0;
                        tgt_d = (tgt_q < want) ? tgt_q + 1'b1 : tgt_q - 1'b1;
                    end
                end
                if (!en_now)
                    st_d = FMT_ST_OFF;
                if (any_flt || peer_fault_in)
                begin
                    cause_d = now;
                    tgt_d = '0;
                    st_d = FMT_ST_FAULT;
                end
            end
            FMT_ST_FAULT:
            begin
                cnt_d = '0;
                if (retry_any)
                    st_d = FMT_ST_WAIT;
                else if (clear_ok && !latch_any)
                    st_d = FMT_ST_DELAY;
                else if (clear_ok && !en_now)
                    st_d = FMT_ST_OFF;
            end
            FMT_ST_WAIT:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= retry_q)
                begin
                    cnt_d = '0;
                    cause_d = '0;
                    st_d = FMT_ST_DELAY;
                end
            end
            default: st_d = FMT_ST_OFF;
        endcase
        if (!en_now && st_q != FMT_ST_FAULT)
            st_d = FMT_ST_OFF;
    end

    // ==========================================================
    // apb register access
    always_comb
    begin
        ctrl_d = {1'b0, ctrl_q[2:0]};
        margin_sel_d = margin_sel_q;
        ot_flt_d = ot_flt_q;
        ut_flt_d = ut_flt_q;
        ot_warn_d = ot_warn_q;
        ut_warn_d = ut_warn_q;
        drv_supply_over_limit_d = drv_supply_over_limit_q;
        drv_supply_under_limit_d = drv_supply_under_limit_q;
        act_d = act_q;
        nom_d = nom_q;
        mhi_d = mhi_q;
        mlo_d = mlo_q;
        rate_d = rate_q;
        track_d = track_q;
        on_dly_d = on_dly_q;
        rise_d = rise_q;
        retry_d = retry_q;
        prdata_d = prdata;
        pready_d = psel && penable && !pready;
        // error decided in the first access cycle so it stands with pready
        pslverr_d = psel && penable && !pready
            && (paddr[1:0] != 2'h0 || paddr > FMT_OFS_RETRY);
        if (wr)
        begin
            case (paddr)
                FMT_OFS_CTRL: ctrl_d = pwdata[3:0];
                FMT_OFS_OPER: margin_sel_d = pwdata[5:4];
                FMT_OFS_TEMP_FLT:
                begin
                    ot_flt_d = pwdata[15:0];
                    ut_flt_d = pwdata[31:16];
                end
                FMT_OFS_TEMP_WARN:
                begin
                    ot_warn_d = pwdata[15:0];
                    ut_warn_d = pwdata[31:16];
                end
                FMT_OFS_DRV_LIM:
                begin
                    drv_supply_over_limit_d = pwdata[15:0];
                    drv_supply_under_limit_d = pwdata[31:16];
                end
                FMT_OFS_ACTION: act_d = pwdata[7:0];
                FMT_OFS_VOUT_NOM: nom_d = pwdata[15:0];
                // margin limits, high capped at plus ten percent
                FMT_OFS_MARGIN:
                begin
                    mhi_d = (pwdata[15:0] > clamp_v) ? clamp_v : pwdata[15:0];
                    mlo_d = pwdata[31:16];
                end
                FMT_OFS_RATE: rate_d = pwdata[7:0];
                FMT_OFS_TRACK: track_d = pwdata[9:0];
                FMT_OFS_ONTIME:
                begin
                    on_dly_d = pwdata[15:0];
                    rise_d = pwdata[31:16];
                end
                FMT_OFS_RETRY: retry_d = pwdata[15:0];
                default: act_d = act_q;
            endcase
        end
        if (rd)
        begin
            case (paddr)
                FMT_OFS_CTRL: prdata_d = {28'h0, ctrl_q};
                FMT_OFS_OPER: prdata_d = {26'h0, margin_sel_q, 4'h0};
                FMT_OFS_TEMP_FLT: prdata_d = {ut_flt_q, ot_flt_q};
                FMT_OFS_TEMP_WARN: prdata_d = {ut_warn_q, ot_warn_q};
                FMT_OFS_DRV_LIM:
                    prdata_d = {drv_supply_under_limit_q, drv_supply_over_limit_q};
                FMT_OFS_ACTION: prdata_d = {24'h0, act_q};
                FMT_OFS_VOUT_NOM: prdata_d = {16'h0, nom_q};
                FMT_OFS_MARGIN: prdata_d = {mlo_q, mhi_q};
                FMT_OFS_RATE: prdata_d = {24'h0, rate_q};
                FMT_OFS_TRACK: prdata_d = {22'h0, track_q};
                FMT_OFS_STATUS: prdata_d = {23'h0, st_q, flt_q};
                FMT_OFS_TARGET: prdata_d = {16'h0, tgt_q};
                FMT_OFS_DRV_READ: prdata_d = {16'h0, drv_read};
                FMT_OFS_ONTIME: prdata_d = {rise_q, on_dly_q};
                FMT_OFS_RETRY: prdata_d = {16'h0, retry_q};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 4'h1;
            margin_sel_q <= FMT_MRG_NOM;
            ot_flt_q <= FMT_OT_FLT_RST;
            ut_flt_q <= FMT_UT_FLT_RST;
            ot_warn_q <= FMT_OT_WARN_RST;
            ut_warn_q <= FMT_UT_WARN_RST;
            drv_supply_over_limit_q <= FMT_DRV_OV_RST;
            drv_supply_under_limit_q <= FMT_DRV_UV_RST;
            act_q <= {FMT_ACT_LATCH, FMT_ACT_LATCH, FMT_ACT_LATCH, FMT_ACT_LATCH};
            nom_q <= FMT_VOUT_NOM_RST;
            mhi_q <= FMT_VOUT_NOM_RST + pct(FMT_VOUT_NOM_RST, FMT_PCT_MARGIN);
            mlo_q <= FMT_VOUT_NOM_RST - pct(FMT_VOUT_NOM_RST, FMT_PCT_MARGIN);
            rate_q <= FMT_RATE_RST;
            track_q <= {1'b0, FMT_RATIO_RST, 2'h0};
            on_dly_q <= FMT_ON_DLY_RST;
            rise_q <= FMT_RISE_RST;
            retry_q <= FMT_RETRY_RST;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            st_q <= FMT_ST_OFF;
            flt_q <= '0;
            cause_q <= '0;
            cnt_q <= '0;
            tgt_q <= '0;
            slew_q <= '0;
            rate_cnt_q <= '0;
            en_q <= 1'b0;
            alert_q <= 1'b0;
            hpr_q <= 1'b0;
            vout_target <= '0;
            output_on <= 1'b0;
            prebias_en <= 1'b0;
            alert_line <= 1'b0;
            host_port_reset <= 1'b0;
            inter_device_fault_bus_o <= 1'b0;
            inter_device_fault_bus_oe <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            margin_sel_q <= margin_sel_d;
            ot_flt_q <= ot_flt_d;
            ut_flt_q <= ut_flt_d;
            ot_warn_q <= ot_warn_d;
            ut_warn_q <= ut_warn_d;
            drv_supply_over_limit_q <= drv_supply_over_limit_d;
            drv_supply_under_limit_q <= drv_supply_under_limit_d;
            act_q <= act_d;
            nom_q <= nom_d;
            mhi_q <= mhi_d;
            mlo_q <= mlo_d;
            rate_q <= rate_d;
            track_q <= track_d;
            on_dly_q <= on_dly_d;
            rise_q <= rise_d;
            retry_q <= retry_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            st_q <= st_d;
            flt_q <= flt_d;
            cause_q <= cause_d;
            cnt_q <= cnt_d;
            tgt_q <= (tgt_d > clamp_v) ? clamp_v : tgt_d;
            slew_q <= slew_d;
            rate_cnt_q <= rate_cnt_d;
            en_q <= en_d;
            alert_q <= alert_d;
            hpr_q <= hpr_d;
            vout_target <= tgt_q;
            output_on <= (st_q == FMT_ST_RUN);
            // no prebias for shared tracking group
            prebias_en <= !(ctrl_q[2] && track_q[1:0] != 2'h0);
            alert_line <= alert_q;
            host_port_reset <= hpr_q;
            // fault broadcast: open drain pulls low, push-pull drives both levels
            inter_device_fault_bus_o <= !(st_q == FMT_ST_FAULT);
            inter_device_fault_bus_oe <= ctrl_q[1] || (st_q == FMT_ST_FAULT);
        end
    end
endmodule

// File: fmt_props.sv
`timescale 1ns/10ps
module fmt_props
    import fmt_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic enable_pin,
    input wire logic peer_fault_in,
    input wire logic output_on,
    input wire logic alert_line,
    input wire logic host_port_reset,
    input wire logic inter_device_fault_bus_o,
    input wire logic inter_device_fault_bus_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic flt;
    // fault bus pulled low only from the fault state
    assign flt = inter_device_fault_bus_oe && !inter_device_fault_bus_o;
    // ==========================================================
    // host port
    property p_ready_once; psel && penable && !pready |=> pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_ready; pslverr |-> pready && psel && penable; endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
    property p_hpr_pulse; host_port_reset |=> !host_port_reset; endproperty
    a_hpr_pulse: assert property (p_hpr_pulse) else $error("port reset held");
    property p_hpr_cause; host_port_reset |-> enable_pin; endproperty
    a_hpr_cause: assert property (p_hpr_cause) else $error("port reset unasked");
    // ==========================================================
    // faults and output
    property p_fault_off; flt |-> !output_on; endproperty
    a_fault_off: assert property (p_fault_off) else $error("on during fault");
    property p_fault_alert; $rose(flt) |-> ##[0:2] alert_line; endproperty
    a_fault_alert: assert property (p_fault_alert) else $error("no alert");
    property p_peer_stop; peer_fault_in && output_on |-> ##[1:3] !output_on; endproperty
    a_peer_stop: assert property (p_peer_stop) else $error("peer fault ignored");
    property p_dis_off; (!enable_pin)[*4] |-> !output_on; endproperty
    a_dis_off: assert property (p_dis_off) else $error("on while disabled");
    cover property (flt);
    cover property (host_port_reset);
    cover property (pslverr);
endmodule

// File: fmt_peer_model.sv
`timescale 1ns/10ps
module fmt_peer_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic inject,
    input wire logic ramp,
    input wire logic bus_o,
    input wire logic bus_oe,
    output logic peer_fault,
    output logic bus_level,
    output logic [15:0] track_ref
);
    logic [1:0] div_q;
    // pull-up always fitted, line never floats
    assign bus_level = bus_oe ? bus_o : 1'b1;
    assign peer_fault = inject;
    // master ramps slowly, only once told
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 2'h0;
            track_ref <= 16'h0000;
        end
        else if (ramp)
        begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3)
                track_ref <= track_ref + 16'h0001;
        end
    end
endmodule

// File: test_fault_margin_track_supervisor.sv
`timescale 1ns/10ps
module test_fault_margin_track_supervisor
    import fmt_pkg::*;
;
    localparam logic [11:0] RETRY_OFS = 12'h038;
    localparam logic [15:0] NOM = FMT_VOUT_NOM_RST;
    localparam logic [15:0] HI5 = NOM + NOM * 16'h0005 / 16'h0064;
    localparam logic [15:0] LO5 = NOM - NOM * 16'h0005 / 16'h0064;
    localparam logic [15:0] CLMP = NOM + NOM * 16'h000a / 16'h0064;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rerr, enable_pin = 0, peer_fault_in, inject = 0, ramp = 0;
    logic signed [15:0] die_temp = 16'sh0019;
    logic [15:0] driver_supply_monitor = 16'h0080, tracking_reference_input, vout_target;
    logic output_on, prebias_en, alert_line, host_port_reset, hpr_seen, bus_level;
    logic inter_device_fault_bus_o, inter_device_fault_bus_oe;
    int err_count = 0, cmp_count = 0, cyc = 0;
    initial forever #2 pclk = ~pclk;
    fmt_supervisor #(.W(16)) u_fmt_supervisor (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_pin, .die_temp,
        .driver_supply_monitor, .tracking_reference_input, .peer_fault_in, .vout_target,
        .output_on, .prebias_en, .alert_line, .host_port_reset, .inter_device_fault_bus_o,
        .inter_device_fault_bus_oe);
    fmt_peer_model u_fmt_peer_model (.pclk, .presetn, .inject, .ramp,
        .bus_o(inter_device_fault_bus_o), .bus_oe(inter_device_fault_bus_oe),
        .peer_fault(peer_fault_in), .bus_level, .track_ref(tracking_reference_input));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1)
            err_count++;
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_on(input logic v);
        int n;
        n = 0;
        while (output_on !== v && n < 600)
        begin
            n++;
            @(posedge pclk);
        end
        chk("output_on", {31'h0, v}, {31'h0, output_on});
    endtask
    task wait_tgt(input logic [15:0] e);
        int n;
        n = 0;
        // slew restarts from zero after a fault: two cycles per code
        while (vout_target !== e && n < 3000)
        begin
            n++;
            @(posedge pclk);
        end
        chk("vout_target", {16'h0, e}, {16'h0, vout_target});
    endtask
    task tally_and_finish;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (host_port_reset === 1'b1)
            hpr_seen <= 1'b1;
        if (cyc == 30000)
        begin
            err_count++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FMT_OFS_TEMP_FLT, 32'h0);
        chk("temp_flt", {FMT_UT_FLT_RST, FMT_OT_FLT_RST}, rd);
        apb(1'b0, FMT_OFS_ACTION, 32'h0);
        chk("action", 32'h0, rd);
        apb(1'b0, FMT_OFS_MARGIN, 32'h0);
        chk("margin", {LO5, HI5}, rd);
        apb(1'b0, 12'h03c, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        chk("unmapped_rd", 32'h0, rd);
        enable_pin <= 1'b1;
        wait_on(1'b1);
        // over temperature with restart; warn limit itself must not restart
        apb(1'b1, FMT_OFS_ACTION, 32'h1);
        die_temp <= 16'sh007e;
        wait_on(1'b0);
        repeat (3) @(posedge pclk);
        chk("bus_level", 32'h0, {31'h0, bus_level});
        chk("alert", 32'h1, {31'h0, alert_line});
        apb(1'b0, FMT_OFS_STATUS, 32'h0);
        chk("status", 32'h8, {28'h0, rd[3:0]});
        die_temp <= 16'sh0073;
        repeat (60) @(posedge pclk);
        chk("held_off", 32'h0, {31'h0, output_on});
        die_temp <= 16'sh0072;
        wait_on(1'b1);
        // under temperature latches until re-enabled
        die_temp <= -16'sh002e;
        wait_on(1'b0);
        die_temp <= 16'sh0019;
        repeat (60) @(posedge pclk);
        chk("latched", 32'h0, {31'h0, output_on});
        hpr_seen <= 1'b0;
        enable_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        enable_pin <= 1'b1;
        wait_on(1'b1);
        chk("port_reset", 32'h1, {31'h0, hpr_seen});
        // driver supply over limit with retry
        apb(1'b1, RETRY_OFS, 32'h4);
        apb(1'b1, FMT_OFS_ACTION, 32'h20);
        apb(1'b1, FMT_OFS_DRV_LIM, 32'h0000_0100);
        driver_supply_monitor <= 16'h0200;
        wait_on(1'b0);
        apb(1'b0, FMT_OFS_DRV_READ, 32'h0);
        chk("drv_read", 32'h2000, rd);
        driver_supply_monitor <= 16'h0080;
        wait_on(1'b1);
        // margin moves slew; oversize margin clamps
        apb(1'b1, FMT_OFS_OPER, 32'h20);
        repeat (3) @(posedge pclk);
        chk("slewing", 32'h0, {31'h0, vout_target === HI5});
        wait_tgt(HI5);
        apb(1'b1, FMT_OFS_MARGIN, {LO5, 16'hffff});
        wait_tgt(CLMP);
        apb(1'b0, FMT_OFS_MARGIN, 32'h0);
        chk("margin_hi", {LO5, CLMP}, rd);
        apb(1'b1, FMT_OFS_OPER, 32'h10);
        wait_tgt(LO5);
        // shared group in tracking skips prebias
        ramp <= 1'b1;
        apb(1'b1, FMT_OFS_TRACK, 32'hc9);
        apb(1'b1, FMT_OFS_CTRL, 32'h5);
        repeat (3) @(posedge pclk);
        chk("prebias", 32'h0, {31'h0, prebias_en});
        inject <= 1'b1;
        wait_on(1'b0);
        tally_and_finish;
    end
endmodule
bind fmt_supervisor fmt_props #(.W(W)) u_fmt_props (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .enable_pin, .peer_fault_in, .output_on, .alert_line,
    .host_port_reset, .inter_device_fault_bus_o, .inter_device_fault_bus_oe);
